/* rtl/image_access_pkg.sv */
package image_access_pkg;

   // ****************************************************************
   // Process image layout
   // ****************************************************************
   localparam int BYTE_W = 8;
   localparam int DATA_W = 16;
   localparam int NUM_W = 6;
   localparam int REG_DEPTH = 64;
   localparam int COMM_BIT = 7;
   localparam int DIR_BIT = 6;
   localparam int NUM_MSB = 5;
   localparam int HI_MSB = 15;
   localparam int HI_LSB = 8;
   localparam int LO_MSB = 7;

   // ****************************************************************
   // Register numbers, keys and reset values
   // ****************************************************************
   localparam logic [5:0] CODE_WORD_NUM = 6'h1F;
   localparam logic [5:0] FEATURE_NUM = 6'h20;
   localparam logic [15:0] UNLOCK_KEY = 16'h1235;
   localparam logic [15:0] CODE_WORD_RESET = 16'h0000;
   localparam logic [15:0] FEATURE_DEFAULT = 16'h0202;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] PROCESS_STATUS = 8'h00;

   // ****************************************************************
   // Sequencer states, Gray along idle, execute, acknowledge
   // ****************************************************************
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_EXEC = 2'h1,
      ST_ACK = 2'h3,
      ST_BOOT = 2'h2
   } state_t;

   // Selects the code word register
   function automatic logic is_code_reg(input logic [5:0] num);
      return num == CODE_WORD_NUM;
   endfunction

   // Builds the receipt of a write: direction bit cleared
   function automatic logic [7:0] write_receipt(input logic [7:0] ctrl);
      logic [7:0] r;
      r = ctrl;
      r[DIR_BIT] = 1'b0;
      return r;
   endfunction

endpackage

/* rtl/reg_store.sv */
`timescale 1ns/10ps
`default_nettype none
module reg_store #(
   parameter int DATA_W = 16,
   parameter int NUM_W = 6,
   parameter int DEPTH = 64
) (
   input wire logic clk_i,
   input wire logic ce_i,
   input wire logic wr_en_i,
   input wire logic [NUM_W-1:0] wr_num_i,
   input wire logic [DATA_W-1:0] wr_data_i,
   input wire logic [NUM_W-1:0] rd_num_i,
   output logic [DATA_W-1:0] rd_data_o
);

   // ****************************************************************
   // Retained register contents
   // ****************************************************************
   logic [DATA_W-1:0] mem [DEPTH];

   // Factory contents; a restart does not touch them
   initial
   begin
      for (int i = 0; i < DEPTH; i++)
      begin
         mem[i] = DATA_W'(image_access_pkg::WORD_ZERO);
      end
      mem[image_access_pkg::FEATURE_NUM] =
         DATA_W'(image_access_pkg::FEATURE_DEFAULT);
   end

   // Write port, frozen while the clock enable is low
   always_ff @(posedge clk_i)
   begin
      if (ce_i && wr_en_i)
      begin
         mem[wr_num_i] <= wr_data_i;
      end
   end

   // Asynchronous read port
   assign rd_data_o = mem[rd_num_i];

endmodule
`default_nettype wire

/* rtl/code_word_guard.sv */
`timescale 1ns/10ps
`default_nettype none
module code_word_guard #(
   parameter int DATA_W = 16
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic load_i,
   input wire logic [DATA_W-1:0] word_i,
   output logic [DATA_W-1:0] code_word_o,
   output logic unlocked_o
);

   // ****************************************************************
   // Code word register and write protection state
   // ****************************************************************

   // Restart clears the code word, so protection is back on
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         code_word_o <= DATA_W'(image_access_pkg::CODE_WORD_RESET);
      end
      else if (ce_i && load_i)
      begin
         code_word_o <= word_i;
      end
   end

   // Only the key lifts protection; any other value sets it again
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         unlocked_o <= 1'b0;
      end
      else if (ce_i && load_i)
      begin
         unlocked_o <= (word_i == DATA_W'(image_access_pkg::UNLOCK_KEY));
      end
   end

endmodule
`default_nettype wire

/* rtl/process_image_register_access.sv */
// Behaviour
// - Locked: only register 31 accepts writes
// - Writing 0x1235 to register 31 unlocks writes
// - Any other code word value relocks writes
// - New feature register values act only after a restart
// - Control bit 7 selects register communication
// - Control bit 6 set writes, clear reads
// - Control bits 5..0 give register number
// - Read receipt echoes control byte unchanged
// - Write receipt echoes control byte, bit 6 cleared
// - Output word ignored during read access
// - Read returns addressed register in input word
// - Data word high byte first, low second
// - Restart clears code word, protection active
`timescale 1ns/10ps
`default_nettype none
module process_image_register_access #(
   parameter int DATA_W = 16,
   parameter int NUM_W = 6,
   parameter int DEPTH = 64
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic image_valid_i,
   input wire logic [7:0] control_byte_i,
   input wire logic [7:0] output_data_hi_i,
   input wire logic [7:0] output_data_lo_i,
   input wire logic [DATA_W-1:0] process_word_i,
   output logic [7:0] status_byte_o,
   output logic [7:0] input_data_hi_o,
   output logic [7:0] input_data_lo_o,
   output logic ack_o,
   output logic write_refused_o,
   output logic [DATA_W-1:0] feature_active_o
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   image_access_pkg::state_t state_reg;
   image_access_pkg::state_t state_next;
   logic [7:0] req_ctrl_reg;
   logic [DATA_W-1:0] req_data_reg;
   logic [DATA_W-1:0] hold_reg;
   logic refused_reg;
   logic take;
   logic comm_req;
   logic req_write;
   logic [NUM_W-1:0] req_num;
   logic req_is_code;
   logic unlocked;
   logic [DATA_W-1:0] code_word;
   logic permitted;
   logic store_wr;
   logic code_wr;
   logic [NUM_W-1:0] rd_num;
   logic [DATA_W-1:0] store_word;
   logic [DATA_W-1:0] read_word;

   // ****************************************************************
   // Request decode
   // ****************************************************************

   // A new image is only taken while idle
   assign take = ce_i && image_valid_i &&
      (state_reg == image_access_pkg::ST_IDLE);
   assign comm_req = control_byte_i[image_access_pkg::COMM_BIT];

   // Fields of the held control byte
   assign req_write = req_ctrl_reg[image_access_pkg::DIR_BIT];
   assign req_num = req_ctrl_reg[image_access_pkg::NUM_MSB:0];
   assign req_is_code = image_access_pkg::is_code_reg(req_num);

   // Register 31 is always writable, the rest only when unlocked
   assign permitted = req_is_code || unlocked;
   assign store_wr = (state_reg == image_access_pkg::ST_EXEC) &&
      req_write && !req_is_code && unlocked;
   assign code_wr = (state_reg == image_access_pkg::ST_EXEC) &&
      req_write && req_is_code;

   // Boot reads the feature register, otherwise the addressed one
   assign rd_num = (state_reg == image_access_pkg::ST_BOOT) ?
      image_access_pkg::FEATURE_NUM : req_num;
   assign read_word = req_is_code ? code_word : store_word;

   // ****************************************************************
   // Sub-blocks
   // ****************************************************************
   reg_store #(
      .DATA_W(DATA_W),
      .NUM_W(NUM_W),
      .DEPTH(DEPTH)
   ) u_store (
      .clk_i(clk_i),
      .ce_i(ce_i),
      .wr_en_i(store_wr),
      .wr_num_i(req_num),
      .wr_data_i(req_data_reg),
      .rd_num_i(rd_num),
      .rd_data_o(store_word)
   );

   code_word_guard #(
      .DATA_W(DATA_W)
   ) u_guard (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .load_i(code_wr),
      .word_i(req_data_reg),
      .code_word_o(code_word),
      .unlocked_o(unlocked)
   );

   // ****************************************************************
   // Sequencer
   // ****************************************************************

   // Next state: boot, idle, execute, acknowledge
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         image_access_pkg::ST_BOOT:
            state_next = image_access_pkg::ST_IDLE;
         image_access_pkg::ST_IDLE:
            if (take && comm_req)
            begin
               state_next = image_access_pkg::ST_EXEC;
            end
         image_access_pkg::ST_EXEC:
            state_next = image_access_pkg::ST_ACK;
         image_access_pkg::ST_ACK:
            state_next = image_access_pkg::ST_IDLE;
         default:
            state_next = image_access_pkg::ST_IDLE;
      endcase
   end

   // State register, restart enters boot
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         state_reg <= image_access_pkg::ST_BOOT;
      end
      else if (ce_i)
      begin
         state_reg <= state_next;
      end
   end

   // ****************************************************************
   // Request capture
   // ****************************************************************

   // Control byte and output word held for the whole access
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         req_ctrl_reg <= image_access_pkg::STATUS_RESET;
         req_data_reg <= DATA_W'(image_access_pkg::WORD_ZERO);
      end
      else if (take && comm_req)
      begin
         req_ctrl_reg <= control_byte_i;
         req_data_reg <= {output_data_hi_i, output_data_lo_i};
      end
   end

   // Read result and refusal latched during execute
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         hold_reg <= DATA_W'(image_access_pkg::WORD_ZERO);
         refused_reg <= 1'b0;
      end
      else if (ce_i && (state_reg == image_access_pkg::ST_EXEC))
      begin
         hold_reg <= read_word;
         refused_reg <= req_write && !permitted;
      end
   end

   // ****************************************************************
   // Input image
   // ****************************************************************

   // Receipt in the status byte
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         status_byte_o <= image_access_pkg::STATUS_RESET;
      end
      else if (take && !comm_req)
      begin
         status_byte_o <= image_access_pkg::PROCESS_STATUS;
      end
      else if (ce_i && (state_reg == image_access_pkg::ST_ACK))
      begin
         if (req_write)
         begin
            status_byte_o <= image_access_pkg::write_receipt(req_ctrl_reg);
         end
         else
         begin
            status_byte_o <= req_ctrl_reg;
         end
      end
   end

   // Input word: read value, process value, or left stale after a write
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         input_data_hi_o <= image_access_pkg::STATUS_RESET;
         input_data_lo_o <= image_access_pkg::STATUS_RESET;
      end
      else if (take && !comm_req)
      begin
         input_data_hi_o <= process_word_i[image_access_pkg::HI_MSB:
            image_access_pkg::HI_LSB];
         input_data_lo_o <= process_word_i[image_access_pkg::LO_MSB:0];
      end
      else if (ce_i && (state_reg == image_access_pkg::ST_ACK) && !req_write)
      begin
         input_data_hi_o <= hold_reg[image_access_pkg::HI_MSB:
            image_access_pkg::HI_LSB];
         input_data_lo_o <= hold_reg[image_access_pkg::LO_MSB:0];
      end
   end

   // One-cycle receipt strobe and refusal flag
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         ack_o <= 1'b0;
         write_refused_o <= 1'b0;
      end
      else if (ce_i)
      begin
         ack_o <= (state_reg == image_access_pkg::ST_ACK);
         if (state_reg == image_access_pkg::ST_ACK)
         begin
            write_refused_o <= refused_reg;
         end
      end
   end

   // Operating configuration, taken from the store only at boot
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         feature_active_o <= DATA_W'(image_access_pkg::FEATURE_DEFAULT);
      end
      else if (ce_i && (state_reg == image_access_pkg::ST_BOOT))
      begin
         feature_active_o <= store_word;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************

   // Store writes happen only with protection lifted
   AST_LOCKED_REJECT: assert property (@(posedge clk_i)
      disable iff (sys_rst_i)
      ce_i && (state_reg == image_access_pkg::ST_EXEC) && req_write &&
      !req_is_code && !unlocked |=> $stable(store_word))
      else $error("write to protected register while locked");

   // Writing the key unlocks on the next enabled edge
   AST_CODE_UNLOCK: assert property (@(posedge clk_i)
      disable iff (sys_rst_i)
      ce_i && code_wr && (req_data_reg == image_access_pkg::UNLOCK_KEY)
      |=> unlocked && (code_word == image_access_pkg::UNLOCK_KEY))
      else $error("code word key did not unlock");

   // Any other value relocks
   AST_CODE_RELOCK: assert property (@(posedge clk_i)
      disable iff (sys_rst_i)
      ce_i && code_wr && (req_data_reg != image_access_pkg::UNLOCK_KEY)
      |=> !unlocked)
      else $error("wrong code word left writes unlocked");

   // Configuration does not follow register writes
   AST_FEATURE_FROZEN: assert property (@(posedge clk_i)
      disable iff (sys_rst_i)
      (state_reg != image_access_pkg::ST_BOOT) |=> $stable(feature_active_o))
      else $error("active configuration changed without restart");

   // Process data images never start an access
   AST_PROCESS_MODE: assert property (@(posedge clk_i)
      disable iff (sys_rst_i)
      take && !comm_req |=> (state_reg == image_access_pkg::ST_IDLE))
      else $error("access started without communication bit");

   // A read never writes, whatever the output word holds
   AST_READ_NO_WRITE: assert property (@(posedge clk_i)
      disable iff (sys_rst_i)
      (state_reg == image_access_pkg::ST_EXEC) && !req_write && ce_i
      |=> $stable(store_word) && $stable(code_word))
      else $error("read access wrote a register");

   // The request number reaches the store intact
   AST_NUMBER: assert property (@(posedge clk_i)
      disable iff (sys_rst_i)
      take && comm_req |=> (req_num == $past(control_byte_i[5:0])))
      else $error("register number not taken from control byte");

   // Read receipt is the control byte unchanged
   AST_READ_ECHO: assert property (@(posedge clk_i)
      disable iff (sys_rst_i)
      ack_o && !req_write |-> (status_byte_o == req_ctrl_reg))
      else $error("read receipt differs from control byte");

   // Write receipt differs only in the direction bit
   AST_WRITE_ECHO: assert property (@(posedge clk_i)
      disable iff (sys_rst_i)
      ack_o && req_write
      |-> ((status_byte_o ^ req_ctrl_reg) == 8'h40))
      else $error("write receipt not control byte with bit 6 cleared");

   // Read data in the input word, high byte first
   AST_READ_DATA: assert property (@(posedge clk_i)
      disable iff (sys_rst_i)
      ack_o && !req_write
      |-> ({input_data_hi_o, input_data_lo_o} == read_word))
      else $error("input word is not the addressed register");

   // Restart leaves protection active
   AST_RESTART_CLEAR: assert property (@(posedge clk_i)
      sys_rst_i |=> !unlocked && (code_word == image_access_pkg::CODE_WORD_RESET))
      else $error("restart did not clear the code word");

   // Receipt follows the take within a bounded time when enabled
   AST_ACK_TIME: assert property (@(posedge clk_i)
      disable iff (sys_rst_i)
      take && comm_req ##1 ce_i [*3] |-> ack_o)
      else $error("receipt missing three enabled cycles after request");

   // ****************************************************************
   // Coverage
   // ****************************************************************
   COV_READ: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      ack_o && !req_write);
   COV_WRITE_OK: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      store_wr && ce_i);
   COV_REFUSED: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      ack_o && write_refused_o);
   COV_UNLOCK: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      $rose(unlocked));

endmodule
`default_nettype wire

/* sim/image_master.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Fieldbus master exchanging the process image
// ****************************************************************
module image_master (
   input wire logic clk_i,
   input wire logic [7:0] status_byte_i,
   input wire logic [7:0] in_hi_i,
   input wire logic [7:0] in_lo_i,
   input wire logic ack_i,
   input wire logic refused_i,
   output logic image_valid_o,
   output logic [7:0] control_byte_o,
   output logic [7:0] out_hi_o,
   output logic [7:0] out_lo_o
);
   // Quiet image at time zero
   initial
   begin
      image_valid_o = 1'b0;
      control_byte_o = 8'h00;
      out_hi_o = 8'h00;
      out_lo_o = 8'h00;
   end

   // Presents a new image for one cycle, returns at the take edge
   task automatic push(input logic [7:0] ctrl, input logic [15:0] word);
      image_valid_o <= 1'b1;
      control_byte_o <= ctrl;
      out_hi_o <= word[15:8];
      out_lo_o <= word[7:0];
      @(posedge clk_i);
      image_valid_o <= 1'b0;
   endtask

   // Register access; image stays put until the receipt pulse
   task automatic access(input logic [7:0] ctrl, input logic [15:0] word,
      output logic [7:0] st, output logic [15:0] rd, output logic rf,
      output int waited);
      st = 8'hXX;
      rd = 16'h0000;
      rf = 1'b0;
      waited = 0;
      push(ctrl, word);
      while (ack_i !== 1'b1 && waited < 40)
      begin
         @(posedge clk_i);
         waited++;
      end
      if (ack_i === 1'b1)
      begin
         st = status_byte_i;
         rf = refused_i;
         if (!ctrl[6])
            rd = {in_hi_i, in_lo_i};
      end
   endtask
endmodule
`default_nettype wire

/* sim/process_image_register_access_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module process_image_register_access_bench;
   // ****************************************************************
   // Clock, reset and wiring
   // ****************************************************************
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic [15:0] process_word_i = 16'h0000;
   logic image_valid;
   logic [7:0] ctrl;
   logic [7:0] out_hi;
   logic [7:0] out_lo;
   logic [7:0] status;
   logic [7:0] in_hi;
   logic [7:0] in_lo;
   logic ack;
   logic refused;
   logic [15:0] feature;
   int fails = 0;
   int comparisons = 0;
   logic [15:0] keys [3] = '{16'h0000, 16'h1234, 16'h1236};

   // Free running 100 MHz clock
   always #5 clk_i = ~clk_i;

   process_image_register_access i_process_image_register_access (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
      .image_valid_i(image_valid), .control_byte_i(ctrl),
      .output_data_hi_i(out_hi), .output_data_lo_i(out_lo),
      .process_word_i(process_word_i), .status_byte_o(status),
      .input_data_hi_o(in_hi), .input_data_lo_o(in_lo), .ack_o(ack),
      .write_refused_o(refused), .feature_active_o(feature)
   );

   image_master i_image_master (
      .clk_i(clk_i), .status_byte_i(status), .in_hi_i(in_hi),
      .in_lo_i(in_lo), .ack_i(ack), .refused_i(refused),
      .image_valid_o(image_valid), .control_byte_o(ctrl),
      .out_hi_o(out_hi), .out_lo_o(out_lo)
   );

   // ****************************************************************
   // Checking and access tasks
   // ****************************************************************
   task end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task check(input logic [15:0] got, input logic [15:0] exp,
      input string what);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task reg_read(input logic [5:0] num, input logic [15:0] exp);
      logic [7:0] st;
      logic [15:0] w;
      logic rf;
      int n;
      i_image_master.access({2'b10, num}, ~exp, st, w, rf, n);
      check({8'h00, st}, {8'h00, 2'b10, num}, "read receipt");
      check(w, exp, "read word");
   endtask

   task reg_write(input logic [5:0] num, input logic [15:0] val,
      input logic refuse);
      logic [7:0] st;
      logic [15:0] w;
      logic rf;
      int n;
      i_image_master.access({2'b11, num}, val, st, w, rf, n);
      check({8'h00, st}, {8'h00, 2'b10, num}, "write receipt");
      check({15'h0000, rf}, {15'h0000, refuse}, "refusal");
   endtask

   task restart(input logic [15:0] feat);
      sys_rst_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      check({8'h00, status}, 16'h0000, "reset status");
      check({in_hi, in_lo}, 16'h0000, "reset word");
      check({14'h0000, ack, refused}, 16'h0000, "reset flags");
      sys_rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      check(feature, feat, "boot feature");
   endtask

   // Cuts a hung run short
   initial
   begin
      repeat (20000) @(posedge clk_i);
      fails++;
      $display("[ERR] %0t watchdog expired", $time);
      end_sim;
   end

   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial
   begin : main
      logic [7:0] st;
      logic [15:0] w;
      logic rf;
      logic seen;
      int n0;
      int n1;
      restart(16'h0202);
      reg_read(6'h1F, 16'h0000);
      reg_write(6'h20, 16'h0002, 1'b1);
      reg_read(6'h20, 16'h0202);
      reg_write(6'h00, 16'hA5C3, 1'b1);
      reg_read(6'h00, 16'h0000);
      $display("test locked done");
      reg_write(6'h1F, 16'h1235, 1'b0);
      reg_read(6'h1F, 16'h1235);
      reg_write(6'h20, 16'h0002, 1'b0);
      reg_read(6'h20, 16'h0002);
      reg_write(6'h00, 16'hA5C3, 1'b0);
      reg_read(6'h00, 16'hA5C3);
      reg_write(6'h3F, 16'h8001, 1'b0);
      reg_read(6'h3F, 16'h8001);
      check(feature, 16'h0202, "feature before restart");
      $display("test unlock done");
      for (int k = 0; k < 3; k++)
      begin
         reg_write(6'h1F, 16'h1235, 1'b0);
         reg_write(6'h1F, keys[k], 1'b0);
         reg_read(6'h1F, keys[k]);
         reg_write(6'h05, 16'h7E81, 1'b1);
         reg_read(6'h05, 16'h0000);
      end
      $display("test relock done");
      for (int k = 0; k < 2; k++)
      begin
         process_word_i <= k[0] ? 16'hC3A5 : 16'h3C5A;
         i_image_master.push(k[0] ? 8'h7F : 8'h00, 16'hFFFF);
         seen = 1'b0;
         @(posedge clk_i);
         check({8'h00, status}, 16'h0000, "process status");
         check({in_hi, in_lo}, k[0] ? 16'hC3A5 : 16'h3C5A, "pword");
         repeat (5)
         begin
            @(posedge clk_i);
            seen = seen | (ack === 1'b1);
         end
         check({15'h0000, seen}, 16'h0000, "no receipt");
      end
      $display("test process mode done");
      i_image_master.access(8'h9F, 16'h0000, st, w, rf, n0);
      fork
         i_image_master.access(8'h9F, 16'h0000, st, w, rf, n1);
         begin
            @(posedge clk_i);
            ce_i <= 1'b0;
            repeat (6) @(posedge clk_i);
            ce_i <= 1'b1;
         end
      join
      check(16'(n1 - n0), 16'h0006, "frozen wait");
      check(w, 16'h1236, "frozen read");
      $display("test clock enable done");
      restart(16'h0002);
      reg_read(6'h1F, 16'h0000);
      reg_write(6'h20, 16'h0202, 1'b1);
      reg_read(6'h20, 16'h0002);
      reg_read(6'h00, 16'hA5C3);
      $display("test restart done");
      end_sim;
   end
endmodule
`default_nettype wire
